// ---- include/vss_pkg.sv ----
// Package for the variable-speed setpoint supervisor
package vss_pkg;
   // -----------------------------------------------------------
   // Widths and speed figures (speed unit is 0.1 % of rated)
   // -----------------------------------------------------------
   localparam int SPD_W = 11;
   localparam logic [10:0] SPD_RATED = 11'h3E8;
   localparam logic [10:0] SET_MIN = 11'h0FA;
   localparam logic [10:0] SET_MAX = 11'h3E8;
   localparam logic [10:0] SET_RST = 11'h3E8;
   localparam logic [10:0] SPD_HYST = 11'h005;
   localparam int STOP_RPM = 60;
   localparam int RATED_RPM_DEF = 30000;
   localparam int CLK_KHZ = 200000;
   localparam int ROT_DELAY_MS = 3000;
   localparam int ROT_DELAY_CYC_DEF = ROT_DELAY_MS * CLK_KHZ;

   // -----------------------------------------------------------
   // Register map and fields
   // -----------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SETPT = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_SPEED = 8'h0C;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_LOW = 1;
   localparam int CTRL_SER = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;

   // -----------------------------------------------------------
   // Types
   // -----------------------------------------------------------
   typedef enum logic [3:0] {
      ST_STOP = 4'b0001,
      ST_ACC = 4'b0010,
      ST_AT = 4'b0100,
      ST_DEC = 4'b1000
   } vss_state_t;

   typedef enum logic [2:0] {
      RS_NORMAL = 3'h0,
      RS_ACCEL = 3'h1,
      RS_SLOWING = 3'h2,
      RS_STOP = 3'h3,
      RS_ALM_STOP = 3'h4,
      RS_ALM_DECEL = 3'h5,
      RS_ALM_IDLE = 3'h6
   } vss_run_t;

   // Remote connector inputs, one bit each
   typedef struct packed {
      logic lowSpeed;
      logic start;
      logic alarm;
      logic coast;
   } vss_pins_t;

   // Remote status outputs
   typedef struct packed {
      logic atSpeed;
      logic accelerating;
      logic slowingDown;
      logic rotating;
   } vss_flags_t;
endpackage : vss_pkg

// ---- core/vss_speed_ctrl.sv ----
// Variable-speed setpoint supervisor with APB register access
`timescale 1ns/1ps
`default_nettype none

module vss_speed_ctrl #(
   parameter int unsigned ROT_DELAY_CYC = vss_pkg::ROT_DELAY_CYC_DEF,
   parameter int unsigned RATED_RPM = vss_pkg::RATED_RPM_DEF
) (
   // Clock, reset, enable
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Remote connector inputs and measured speed
   input wire vss_pkg::vss_pins_t remPins,
   input wire logic [10:0] measSpeed,
   // Remote status and drive outputs
   output vss_pkg::vss_flags_t remFlags,
   output vss_pkg::vss_run_t runStatus,
   output logic [10:0] driveTarget,
   output logic driveRun
);
   // -----------------------------------------------------------
   // Derived constants
   // -----------------------------------------------------------
   localparam logic [10:0] STOP_SPD =
      11'((vss_pkg::STOP_RPM * 1000) / RATED_RPM);

   // 80 % of a speed value
   function automatic logic [10:0] pct80(input logic [10:0] v);
      logic [13:0] w;
      w = {3'h0, v} * 14'h4;
      pct80 = 11'(w / 14'h5);
   endfunction : pct80

   // -----------------------------------------------------------
   // Pin synchroniser, three stages, change on stage 2/3 agree
   // -----------------------------------------------------------
   vss_pkg::vss_pins_t s1_r, s2_r, s3_r, pin_r;

   // Shift chain
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else if (clkEn) begin
         s1_r <= remPins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Filtered pin levels
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         pin_r <= '0;
      end else if (clkEn) begin
         for (int i = 0; i < 4; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               pin_r[i] <= s3_r[i];
            end
         end
      end
   end

   // -----------------------------------------------------------
   // APB register file
   // -----------------------------------------------------------
   logic [2:0] ctrl_r;
   logic [10:0] setpt_r;
   logic apbAcc, apbWr, setOk, addrOk;
   vss_pkg::vss_state_t state_r, state_nxt;
   logic rot_r, atSpd_r, accel_r, slow_r;

   // Flag outputs gathered from one register per flag
   assign remFlags = {atSpd_r, accel_r, slow_r, rot_r};

   assign pready = clkEn;
   assign apbAcc = psel && penable && clkEn;
   assign apbWr = apbAcc && pwrite;
   assign setOk = (pwdata[31:11] == 21'h0) &&
                  (pwdata[10:0] >= vss_pkg::SET_MIN) &&
                  (pwdata[10:0] <= vss_pkg::SET_MAX);
   assign addrOk = (paddr == vss_pkg::ADDR_CTRL) ||
                   (paddr == vss_pkg::ADDR_SETPT) ||
                   (paddr == vss_pkg::ADDR_STAT) ||
                   (paddr == vss_pkg::ADDR_SPEED);

   // Error answer: unmapped address or rejected setpoint
   always_comb begin
      pslverr = 1'b0;
      if (psel && penable) begin
         pslverr = !addrOk ||
                   (pwrite && paddr == vss_pkg::ADDR_SETPT && !setOk);
      end
   end

   // Control bits: serial start, serial low select, source
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ctrl_r <= vss_pkg::CTRL_RST;
      end else if (apbWr && paddr == vss_pkg::ADDR_CTRL) begin
         ctrl_r <= pwdata[2:0];
      end
   end

   // Setpoint, kept until the next valid write
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         setpt_r <= vss_pkg::SET_RST;
      end else if (apbWr && paddr == vss_pkg::ADDR_SETPT && setOk) begin
         setpt_r <= pwdata[10:0];
      end
   end

   // Read data, registered at the setup phase
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0;
      end else if (clkEn && psel && !penable) begin
         case (paddr)
            vss_pkg::ADDR_CTRL: prdata <= {29'h0, ctrl_r};
            vss_pkg::ADDR_SETPT: prdata <= {21'h0, setpt_r};
            vss_pkg::ADDR_STAT:
               prdata <= {21'h0, state_r, runStatus, remFlags};
            vss_pkg::ADDR_SPEED: prdata <= {21'h0, measSpeed};
            default: prdata <= 32'h0;
         endcase
      end
   end

   // -----------------------------------------------------------
   // Command selection and target speed
   // -----------------------------------------------------------
   logic serSrc, lowMode, runOn;
   logic [10:0] tgt, tgt80, tgtHi;

   assign serSrc = ctrl_r[vss_pkg::CTRL_SER];
   // Mode from pin or serial bit, live in any state
   assign lowMode = serSrc ? ctrl_r[vss_pkg::CTRL_LOW]
                           : pin_r.lowSpeed;
   assign runOn = (serSrc ? ctrl_r[vss_pkg::CTRL_RUN] : pin_r.start) &&
                  !pin_r.alarm;
   // Target: zero when stopping, else rated or setpoint
   assign tgt = !runOn ? 11'h0 :
                lowMode ? setpt_r : vss_pkg::SPD_RATED;
   assign tgt80 = pct80(tgt);
   assign tgtHi = tgt + vss_pkg::SPD_HYST;

   // -----------------------------------------------------------
   // Speed state machine, compared each cycle
   // -----------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         vss_pkg::ST_STOP: begin
            if (runOn) begin
               state_nxt = vss_pkg::ST_ACC;
            end
         end
         vss_pkg::ST_ACC: begin
            if (!runOn || measSpeed > tgtHi) begin
               state_nxt = vss_pkg::ST_DEC;
            end else if (measSpeed >= tgt80) begin
               state_nxt = vss_pkg::ST_AT;
            end
         end
         vss_pkg::ST_AT: begin
            if (!runOn || measSpeed > tgtHi) begin
               state_nxt = vss_pkg::ST_DEC;
            end else if (measSpeed < tgt80) begin
               state_nxt = vss_pkg::ST_ACC;
            end
            // Otherwise hold, even while ramping up
         end
         vss_pkg::ST_DEC: begin
            if (!runOn) begin
               if (measSpeed <= STOP_SPD) begin
                  state_nxt = vss_pkg::ST_STOP;
               end
            end else if (measSpeed < tgt80) begin
               state_nxt = vss_pkg::ST_ACC;
            end else if (measSpeed <= tgt) begin
               state_nxt = vss_pkg::ST_AT;
            end
         end
         default: state_nxt = vss_pkg::ST_STOP;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_r <= vss_pkg::ST_STOP;
      end else if (clkEn) begin
         state_r <= state_nxt;
      end
   end

   // Drive command; the drive ramps at its normal rates
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         driveTarget <= 11'h0;
         driveRun <= 1'b0;
      end else if (clkEn) begin
         driveTarget <= tgt;
         driveRun <= runOn;
      end
   end

   // -----------------------------------------------------------
   // Rotating flag: delayed set after start, clear near rest
   // -----------------------------------------------------------
   logic [31:0] rotCnt_r;
   logic rotPend_r;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rotCnt_r <= 32'h0;
         rotPend_r <= 1'b0;
         rot_r <= 1'b0;
      end else if (clkEn) begin
         if (state_r == vss_pkg::ST_STOP && state_nxt == vss_pkg::ST_ACC) begin
            rotCnt_r <= 32'h0;
            rotPend_r <= 1'b1;
         end else if (rotPend_r) begin
            rotCnt_r <= rotCnt_r + 32'h1;
            if (rotCnt_r >= 32'(ROT_DELAY_CYC - 1)) begin
               rotPend_r <= 1'b0;
               rot_r <= 1'b1;
            end
         end
         if (measSpeed <= STOP_SPD && state_nxt == vss_pkg::ST_STOP) begin
            rot_r <= 1'b0;
            rotPend_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------
   // Status flags and run status from the next state
   // -----------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         atSpd_r <= 1'b0;
         accel_r <= 1'b0;
         slow_r <= 1'b0;
      end else if (clkEn) begin
         atSpd_r <= (state_nxt == vss_pkg::ST_AT);
         accel_r <= (state_nxt == vss_pkg::ST_ACC);
         slow_r <= (state_nxt == vss_pkg::ST_DEC);
      end
   end

   // Run status, alarm variants take precedence
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         runStatus <= vss_pkg::RS_STOP;
      end else if (clkEn) begin
         if (pin_r.alarm) begin
            if (state_nxt == vss_pkg::ST_STOP) begin
               runStatus <= vss_pkg::RS_ALM_STOP;
            end else if (pin_r.coast) begin
               runStatus <= vss_pkg::RS_ALM_IDLE;
            end else begin
               runStatus <= vss_pkg::RS_ALM_DECEL;
            end
         end else begin
            case (state_nxt)
               vss_pkg::ST_ACC: runStatus <= vss_pkg::RS_ACCEL;
               vss_pkg::ST_AT: runStatus <= vss_pkg::RS_NORMAL;
               vss_pkg::ST_DEC: runStatus <= vss_pkg::RS_SLOWING;
               default: runStatus <= vss_pkg::RS_STOP;
            endcase
         end
      end
   end
endmodule : vss_speed_ctrl

`default_nettype wire

// ---- tb/vss_speed_ctrl_asserts.sv ----
// Checker for the setpoint supervisor outputs
`timescale 1ns/1ps
`default_nettype none
module vss_speed_ctrl_asserts #(
   parameter int unsigned ROT_DELAY_CYC = 20
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Watched speed and outputs
   input wire logic [10:0] measSpeed,
   input wire vss_pkg::vss_flags_t remFlags,
   input wire vss_pkg::vss_run_t runStatus,
   input wire logic [10:0] driveTarget,
   input wire logic driveRun
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Flag, status and target relations
   // ----------------------------------------
   a_start_accel: assert property ($rose(driveRun) |-> runStatus == vss_pkg::RS_ACCEL)
      else $error("start without accelerating status");
   a_rot_late: assert property ($rose(driveRun) |-> !remFlags.rotating [*8])
      else $error("rotating flag came too early");
   a_acc_flag: assert property (remFlags.accelerating == (runStatus == vss_pkg::RS_ACCEL))
      else $error("accelerating flag and status differ");
   a_slow_flag: assert property (remFlags.slowingDown == (runStatus == vss_pkg::RS_SLOWING))
      else $error("slowing flag and status differ");
   a_at_status: assert property (remFlags.atSpeed |-> runStatus == vss_pkg::RS_NORMAL)
      else $error("at-speed flag without normal status");
   a_stop_rot: assert property (runStatus == vss_pkg::RS_STOP |-> !remFlags.rotating)
      else $error("rotating while stopped");
   a_at_thresh: assert property ($rose(remFlags.atSpeed) && $past(remFlags.accelerating)
      |-> 10 * $past(measSpeed) >= 8 * $past(driveTarget))
      else $error("at-speed below eighty percent");
   a_target_rng: assert property (driveTarget != 0
      |-> driveTarget >= vss_pkg::SET_MIN && driveTarget <= vss_pkg::SET_MAX)
      else $error("target out of range");
endmodule : vss_speed_ctrl_asserts
bind vss_speed_ctrl vss_speed_ctrl_asserts #(.ROT_DELAY_CYC(ROT_DELAY_CYC)) u_asserts (
   .ref_clk, .sys_rst, .measSpeed, .remFlags, .runStatus, .driveTarget, .driveRun);
`default_nettype wire

// ---- tb/vss_rotor_model.sv ----
// Rotor speed model that ramps toward the drive target
`timescale 1ns/1ps
`default_nettype none
module vss_rotor_model #(
   parameter int STEP = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // Drive command
   input wire logic driveRun,
   input wire logic [10:0] driveTarget,
   // Measured speed
   output logic [10:0] measSpeed
);
   logic [10:0] goal;
   // Coasts to rest when not commanded
   assign goal = driveRun ? driveTarget : 11'h000;
   // One ramp rate both ways, exact hold at the goal
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         measSpeed <= 11'h000;
      end else if (measSpeed + STEP <= goal) begin
         measSpeed <= measSpeed + 11'(STEP);
      end else if (measSpeed >= goal + STEP) begin
         measSpeed <= measSpeed - 11'(STEP);
      end else begin
         measSpeed <= goal;
      end
   end
endmodule : vss_rotor_model
`default_nettype wire

// ---- tb/vss_speed_ctrl_tb.sv ----
// Self-checking bench for the setpoint supervisor
`timescale 1ns/1ps
`default_nettype none
module vss_speed_ctrl_tb;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clkEn = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   vss_pkg::vss_pins_t remPins = 4'h0;
   logic [10:0] measSpeed;
   vss_pkg::vss_flags_t remFlags;
   vss_pkg::vss_run_t runStatus;
   logic [10:0] driveTarget;
   logic driveRun;
   logic [31:0] rd;
   logic er;
   int n_mismatch = 0;
   int num_checks = 0;
   // Clock
   always #2.5 ref_clk = ~ref_clk;
   vss_speed_ctrl #(.ROT_DELAY_CYC(20), .RATED_RPM(30000)) u_vss_speed_ctrl (
      .ref_clk, .sys_rst, .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .remPins, .measSpeed, .remFlags, .runStatus,
      .driveTarget, .driveRun);
   vss_rotor_model u_vss_rotor_model (.ref_clk, .sys_rst, .driveRun, .driveTarget, .measSpeed);
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic report_and_stop;
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (n > 50) begin
            n_mismatch++;
            report_and_stop();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Bounded wait for a speed or a run status
   task automatic wait_for(input logic sp, input logic [10:0] v);
      int n;
      n = 0;
      while ((sp ? measSpeed : {8'h00, runStatus}) !== v) begin
         @(negedge ref_clk);
         n++;
         if (n > 5000) begin
            n_mismatch++;
            report_and_stop();
         end
      end
   endtask : wait_for
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      apb(1'b0, vss_pkg::ADDR_SETPT, 32'h0);
      chk("setpt rst", rd, 32'h3E8);
      apb(1'b0, vss_pkg::ADDR_STAT, 32'h0);
      chk("stat rst", rd, 32'hB0);
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'hF9);
      chk("low err", er, 1'b1);
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'h3E9);
      chk("high err", er, 1'b1);
      apb(1'b0, vss_pkg::ADDR_SETPT, 32'h0);
      chk("setpt kept", rd, 32'h3E8);
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'hFA);
      apb(1'b0, vss_pkg::ADDR_SETPT, 32'h0);
      chk("setpt min", rd, 32'hFA);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", er, 1'b1);
   endtask : t_regs
   task automatic t_low_start;
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'h1F4);
      apb(1'b1, vss_pkg::ADDR_CTRL, 32'h7);
      wait_for(1'b0, vss_pkg::RS_ACCEL);
      chk("acc flags", remFlags, 4'h4);
      chk("low target", driveTarget, 11'h1F4);
      wait_for(1'b0, vss_pkg::RS_NORMAL);
      chk("at 80pct", measSpeed >= 400 && measSpeed <= 404, 1'b1);
      wait_for(1'b1, 11'h1F4);
      repeat (20) @(negedge ref_clk);
      chk("held low", measSpeed, 11'h1F4);
      chk("low flags", remFlags, 4'h9);
   endtask : t_low_start
   task automatic t_return;
      apb(1'b1, vss_pkg::ADDR_CTRL, 32'h5);
      wait_for(1'b0, vss_pkg::RS_ACCEL);
      chk("ret target", driveTarget, 11'h3E8);
      wait_for(1'b0, vss_pkg::RS_NORMAL);
      chk("ret 80pct", measSpeed >= 800 && measSpeed <= 804, 1'b1);
      wait_for(1'b1, 11'h3E8);
      chk("rated flags", remFlags, 4'h9);
      // Frozen block: no ready, status held
      @(posedge ref_clk);
      clkEn <= 1'b0;
      repeat (5) @(negedge ref_clk);
      chk("frozen rdy", pready, 1'b0);
      chk("frozen st", runStatus, vss_pkg::RS_NORMAL);
      @(posedge ref_clk);
      clkEn <= 1'b1;
   endtask : t_return
   task automatic t_reduce;
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'h384);
      apb(1'b1, vss_pkg::ADDR_CTRL, 32'h7);
      wait_for(1'b0, vss_pkg::RS_SLOWING);
      chk("slow flags", remFlags, 4'h3);
      wait_for(1'b0, vss_pkg::RS_NORMAL);
      chk("slow end", measSpeed, 11'h384);
      apb(1'b1, vss_pkg::ADDR_CTRL, 32'h5);
      for (int i = 0; i < 60; i++) begin
         @(negedge ref_clk);
         chk("high ret", {runStatus, remFlags}, {vss_pkg::RS_NORMAL, 4'h9});
      end
      chk("rated", measSpeed, 11'h3E8);
   endtask : t_reduce
   task automatic t_pins;
      @(posedge ref_clk);
      remPins <= 4'h0;
      apb(1'b1, vss_pkg::ADDR_CTRL, 32'h0);
      wait_for(1'b0, vss_pkg::RS_STOP);
      chk("stop", {remFlags, measSpeed <= 2}, 5'h01);
      @(posedge ref_clk);
      remPins.start <= 1'b1;
      wait_for(1'b1, 11'h0C8);
      @(posedge ref_clk);
      remPins.lowSpeed <= 1'b1;
      wait_for(1'b1, 11'h384);
      repeat (20) @(negedge ref_clk);
      chk("late low", {runStatus, measSpeed}, {vss_pkg::RS_NORMAL, 11'h384});
      apb(1'b1, vss_pkg::ADDR_SETPT, 32'h320);
      wait_for(1'b1, 11'h320);
      repeat (20) @(negedge ref_clk);
      chk("new setpt", {runStatus, measSpeed}, {vss_pkg::RS_NORMAL, 11'h320});
      @(posedge ref_clk);
      remPins.start <= 1'b0;
      wait_for(1'b0, vss_pkg::RS_STOP);
      chk("pin stop", {remFlags, measSpeed <= 2}, 5'h01);
      // Alarm pin while stopped gives the alarm-stop status
      @(posedge ref_clk);
      remPins.alarm <= 1'b1;
      wait_for(1'b0, vss_pkg::RS_ALM_STOP);
      chk("alm stop", {remFlags, driveRun}, 5'h00);
      @(posedge ref_clk);
      remPins.alarm <= 1'b0;
      wait_for(1'b0, vss_pkg::RS_STOP);
      chk("alm clear", runStatus, vss_pkg::RS_STOP);
   endtask : t_pins
   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_low_start();
      t_return();
      t_reduce();
      t_pins();
      report_and_stop();
   end
endmodule : vss_speed_ctrl_tb
`default_nettype wire
